// [hw/sdram_command_decoder.sv]
// Command decoder: pin levels in, decoded command and burst state out
// Function
// - Decode command pins at rising clock edge
// - Bank bits pick bank or mode register
// - Bursts run to completion; mode selects length
// - No refresh performed while in power-down
// - Termination ignored by decode; off in self-refresh
// - Self-refresh exit on cke high with nop/deselect
// - No-operation never cancels running burst
// - Deselect behaves like no-operation; only the code on cmd_out differs
// - Write encoding; chop bit low selects four
// - Fixed-length write ignores chop bit level
// - Read encoding; chop bit selects four or eight
// - Write with auto-precharge closes bank after burst
// - Read with auto-precharge closes bank after burst
module sdram_command_decoder #(
    parameter int BANK_W = cmd_decode_pkg::BANK_W
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic reset_n_pin,
    input wire cmd_decode_pkg::pins_s pins,
    input wire logic termination_control,
    input wire logic burst_on_fly_mode,
    input wire logic fixed_chop_mode,
    output cmd_decode_pkg::dec_s cmd_out,
    output logic cmd_valid,
    output logic [cmd_decode_pkg::MR_SEL_W-1:0] mode_register_select,
    output logic burst_active,
    output logic auto_precharge_done,
    output logic [BANK_W-1:0] auto_precharge_bank,
    output logic refresh_start,
    output logic termination_enable,
    output cmd_decode_pkg::pwr_e power_state
);
    // ==========================================================
    // Input synchronisers; the reset pin is synchronised too
    cmd_decode_pkg::pins_s pins_m_r, pins_s_r;
    logic term_m_r, term_s_r, rst_m_r, rst_s_r, cke_prev_r;
    cmd_decode_pkg::pwr_e power_r, power_nxt;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pins_m_r <= cmd_decode_pkg::PINS_RESET;
            pins_s_r <= cmd_decode_pkg::PINS_RESET;
            term_m_r <= 1'b0;
            term_s_r <= 1'b0;
            rst_m_r <= 1'b0;
            rst_s_r <= 1'b0;
            cke_prev_r <= cmd_decode_pkg::PINS_RESET.cke;
        end else if (clk_en) begin
            pins_m_r <= pins;
            pins_s_r <= pins_m_r;
            term_m_r <= termination_control;
            term_s_r <= term_m_r;
            rst_m_r <= reset_n_pin;
            rst_s_r <= rst_m_r;
            cke_prev_r <= pins_s_r.cke;
        end
    end

    // ==========================================================
    // Pure decode of one sampled edge
    cmd_decode_pkg::dec_s dec;
    always_comb begin
        dec.bank = pins_s_r.bank;
        dec.auto_precharge = 1'b0;
        dec.chopped_burst_four = 1'b0;
        dec.cmd = cmd_decode_pkg::CMD_ILLEGAL;
        // decoded from cke history, strobes, auto_precharge_bit and power state; termination is not looked at
        if (!cke_prev_r) begin
            if (pins_s_r.cke && (pins_s_r.cs_n || (pins_s_r.ras_n && pins_s_r.cas_n && pins_s_r.we_n)))
                dec.cmd = (power_r == cmd_decode_pkg::ST_SELF_REFRESH) ? cmd_decode_pkg::CMD_SELF_REFRESH_EXIT
                                                                      : cmd_decode_pkg::CMD_POWER_DOWN_EXIT;
            else if (!pins_s_r.cke)
                dec.cmd = cmd_decode_pkg::CMD_DESELECT;
        end else if (!pins_s_r.cke) begin
            if (pins_s_r.cs_n || (pins_s_r.ras_n && pins_s_r.cas_n && pins_s_r.we_n))
                dec.cmd = cmd_decode_pkg::CMD_POWER_DOWN_ENTRY;
            else if (!pins_s_r.ras_n && !pins_s_r.cas_n && pins_s_r.we_n)
                dec.cmd = cmd_decode_pkg::CMD_SELF_REFRESH_ENTRY;
        end else if (pins_s_r.cs_n) begin
            dec.cmd = cmd_decode_pkg::CMD_DESELECT;
        end else begin
            case ({pins_s_r.ras_n, pins_s_r.cas_n, pins_s_r.we_n})
                3'b000: dec.cmd = cmd_decode_pkg::CMD_MODE_REGISTER_SET;
                3'b001: dec.cmd = cmd_decode_pkg::CMD_REFRESH;
                3'b010: dec.cmd = pins_s_r.auto_precharge_bit ? cmd_decode_pkg::CMD_PRECHARGE_ALL
                                                              : cmd_decode_pkg::CMD_PRECHARGE;
                3'b011: dec.cmd = cmd_decode_pkg::CMD_ACTIVATE;
                3'b100, 3'b101: begin
                    dec.cmd = pins_s_r.we_n ? cmd_decode_pkg::CMD_READ : cmd_decode_pkg::CMD_WRITE;
                    dec.auto_precharge = pins_s_r.auto_precharge_bit;
                    // fixed mode ignores the chop bit level
                    dec.chopped_burst_four = burst_on_fly_mode ? !pins_s_r.burst_chop_bit : fixed_chop_mode;
                end
                3'b110: dec.cmd = pins_s_r.auto_precharge_bit ? cmd_decode_pkg::CMD_CALIBRATION_LONG
                                                              : cmd_decode_pkg::CMD_CALIBRATION_SHORT;
                3'b111: dec.cmd = cmd_decode_pkg::CMD_NOP;
                default: dec.cmd = cmd_decode_pkg::CMD_ILLEGAL;
            endcase
        end
    end

    // ==========================================================
    // Power state and burst tracking
    logic [3:0] burst_cnt_r, burst_cnt_nxt;
    logic ap_pend_r, ap_pend_nxt;
    logic [BANK_W-1:0] ap_bank_r, ap_bank_nxt;
    logic ap_done_nxt, refresh_nxt, term_nxt, valid_nxt, is_burst, burst_active_nxt;

    assign is_burst = (dec.cmd == cmd_decode_pkg::CMD_READ) || (dec.cmd == cmd_decode_pkg::CMD_WRITE);

    always_comb begin
        power_nxt = power_r;
        burst_cnt_nxt = burst_cnt_r;
        ap_pend_nxt = ap_pend_r;
        ap_bank_nxt = ap_bank_r;
        ap_done_nxt = 1'b0;
        case (dec.cmd)
            cmd_decode_pkg::CMD_SELF_REFRESH_ENTRY: power_nxt = cmd_decode_pkg::ST_SELF_REFRESH;
            cmd_decode_pkg::CMD_POWER_DOWN_ENTRY: power_nxt = cmd_decode_pkg::ST_POWER_DOWN;
            cmd_decode_pkg::CMD_SELF_REFRESH_EXIT, cmd_decode_pkg::CMD_POWER_DOWN_EXIT:
                power_nxt = cmd_decode_pkg::ST_ACTIVE;
            default: power_nxt = power_r;
        endcase
        // a running burst counts down whatever arrives; new bursts only start when idle
        if (burst_cnt_r != 4'h0) begin
            burst_cnt_nxt = burst_cnt_r - 4'h1;
            if (burst_cnt_r == 4'h1 && ap_pend_r) begin
                ap_done_nxt = 1'b1;
                ap_pend_nxt = 1'b0;
            end
        end else if (is_burst) begin
            burst_cnt_nxt = dec.chopped_burst_four ? 4'(cmd_decode_pkg::BURST_CHOP_BEATS)
                                                   : 4'(cmd_decode_pkg::BURST_FULL_BEATS);
            ap_pend_nxt = dec.auto_precharge;
            ap_bank_nxt = dec.bank;
        end
        refresh_nxt = (dec.cmd == cmd_decode_pkg::CMD_REFRESH) && (power_r == cmd_decode_pkg::ST_ACTIVE);
        term_nxt = term_s_r && (power_nxt != cmd_decode_pkg::ST_SELF_REFRESH);
        valid_nxt = (dec.cmd != cmd_decode_pkg::CMD_DESELECT) && (dec.cmd != cmd_decode_pkg::CMD_NOP);
        burst_active_nxt = (burst_cnt_nxt != 4'h0);
    end

    // Pin reset is folded in synchronously so reset_n_pin feeds no async reset path
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            power_r <= cmd_decode_pkg::ST_ACTIVE;
            burst_cnt_r <= cmd_decode_pkg::BURST_CNT_RESET;
            ap_pend_r <= 1'b0;
            ap_bank_r <= '0;
            cmd_out <= '0;
            cmd_valid <= 1'b0;
            burst_active <= 1'b0;
            mode_register_select <= '0;
            auto_precharge_done <= 1'b0;
            refresh_start <= 1'b0;
            termination_enable <= 1'b0;
        end else if (clk_en) begin
            if (!rst_s_r) begin
                power_r <= cmd_decode_pkg::ST_ACTIVE;
                burst_cnt_r <= cmd_decode_pkg::BURST_CNT_RESET;
                ap_pend_r <= 1'b0;
                cmd_valid <= 1'b0;
                burst_active <= 1'b0;
                auto_precharge_done <= 1'b0;
                refresh_start <= 1'b0;
                termination_enable <= 1'b0;
            end else begin
                power_r <= power_nxt;
                burst_cnt_r <= burst_cnt_nxt;
                burst_active <= burst_active_nxt;
                ap_pend_r <= ap_pend_nxt;
                ap_bank_r <= ap_bank_nxt;
                cmd_out <= dec;
                cmd_valid <= valid_nxt;
                if (dec.cmd == cmd_decode_pkg::CMD_MODE_REGISTER_SET)
                    mode_register_select <= dec.bank[cmd_decode_pkg::MR_SEL_W-1:0];
                auto_precharge_done <= ap_done_nxt;
                refresh_start <= refresh_nxt;
                termination_enable <= term_nxt;
            end
        end
    end

    assign auto_precharge_bank = ap_bank_r;
    assign power_state = power_r;

    // ==========================================================
    // Checks
    sequence s_burst_start;
        cmd_valid && cmd_out.cmd inside {cmd_decode_pkg::CMD_READ, cmd_decode_pkg::CMD_WRITE};
    endsequence

    a_deselect_is_nop: assert property (@(posedge clk) disable iff (reset)
        clk_en && rst_s_r && cke_prev_r && pins_s_r.cke && pins_s_r.cs_n |=> !cmd_valid)
        else $error("deselect produced a command");
    a_no_pd_refresh: assert property (@(posedge clk) disable iff (reset)
        refresh_start |-> $past(power_r) == cmd_decode_pkg::ST_ACTIVE)
        else $error("refresh while powered down");
    a_sr_no_term: assert property (@(posedge clk) disable iff (reset)
        power_r == cmd_decode_pkg::ST_SELF_REFRESH |-> !termination_enable)
        else $error("termination on in self refresh");
    a_sr_exit_wakes: assert property (@(posedge clk) disable iff (reset)
        clk_en && rst_s_r && dec.cmd == cmd_decode_pkg::CMD_SELF_REFRESH_EXIT
        |=> power_r == cmd_decode_pkg::ST_ACTIVE)
        else $error("self refresh exit missed");
    a_burst_runs_on: assert property (@(posedge clk) disable iff (reset)
        clk_en && rst_s_r && burst_cnt_r > 4'h1 |=> burst_cnt_r == $past(burst_cnt_r) - 4'h1)
        else $error("burst interrupted");
    a_write_decode: assert property (@(posedge clk) disable iff (reset)
        cke_prev_r && pins_s_r.cke && !pins_s_r.cs_n && pins_s_r.ras_n && !pins_s_r.cas_n && !pins_s_r.we_n
        |-> dec.cmd == cmd_decode_pkg::CMD_WRITE)
        else $error("write misdecoded");
    a_chop_on_fly: assert property (@(posedge clk) disable iff (reset)
        is_burst && burst_on_fly_mode |-> dec.chopped_burst_four == !pins_s_r.burst_chop_bit)
        else $error("chop bit misread");
    a_mr_select: assert property (@(posedge clk) disable iff (reset)
        clk_en && rst_s_r && dec.cmd == cmd_decode_pkg::CMD_MODE_REGISTER_SET
        |=> mode_register_select == $past(pins_s_r.bank[1:0]))
        else $error("mode register select wrong");
    a_ap_closes: assert property (@(posedge clk) disable iff (reset)
        clk_en && rst_s_r && burst_cnt_r == 4'h1 && ap_pend_r |=> auto_precharge_done)
        else $error("auto precharge missed");
    a_pde_decode: assert property (@(posedge clk) disable iff (reset)
        cke_prev_r && !pins_s_r.cke && pins_s_r.cs_n |-> dec.cmd == cmd_decode_pkg::CMD_POWER_DOWN_ENTRY)
        else $error("power down entry missed");
    a_burst_seen: assert property (@(posedge clk) disable iff (reset)
        $rose(burst_active) |-> s_burst_start)
        else $error("burst start inconsistent");
endmodule : sdram_command_decoder

// [hw/cmd_decode_pkg.sv]
// Shared constants and types for the command decoder
package cmd_decode_pkg;
    // ==========================================================
    // Command codes
    typedef enum logic [4:0] {
        CMD_DESELECT = 5'h00,
        CMD_NOP = 5'h01,
        CMD_MODE_REGISTER_SET = 5'h02,
        CMD_REFRESH = 5'h03,
        CMD_SELF_REFRESH_ENTRY = 5'h04,
        CMD_SELF_REFRESH_EXIT = 5'h05,
        CMD_PRECHARGE = 5'h06,
        CMD_PRECHARGE_ALL = 5'h07,
        CMD_ACTIVATE = 5'h08,
        CMD_WRITE = 5'h09,
        CMD_READ = 5'h0a,
        CMD_POWER_DOWN_ENTRY = 5'h0b,
        CMD_POWER_DOWN_EXIT = 5'h0c,
        CMD_CALIBRATION_LONG = 5'h0d,
        CMD_CALIBRATION_SHORT = 5'h0e,
        CMD_ILLEGAL = 5'h0f
    } cmd_e;

    // ==========================================================
    // Device power state
    typedef enum logic [1:0] {
        ST_ACTIVE = 2'b00,
        ST_POWER_DOWN = 2'b01,
        ST_SELF_REFRESH = 2'b10
    } pwr_e;

    // ==========================================================
    // Field layout and reset values
    localparam int BANK_W = 3;
    localparam int MR_SEL_W = 2;
    localparam int BURST_FULL_BEATS = 8;
    localparam int BURST_CHOP_BEATS = 4;
    localparam logic [3:0] BURST_CNT_RESET = 4'h0;

    // Pin levels of one clock edge; strobes active low
    typedef struct packed {
        logic cke;
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic auto_precharge_bit;
        logic burst_chop_bit;
        logic [BANK_W-1:0] bank;
    } pins_s;

    // Synchroniser reset level: a deselect with cke high, so release shows no cke edge
    localparam pins_s PINS_RESET = '{cke: 1'b1, cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, default: '0};

    // Decoded command with its qualifiers
    typedef struct packed {
        cmd_e cmd;
        logic [BANK_W-1:0] bank;
        logic auto_precharge;
        logic chopped_burst_four;
    } dec_s;
endpackage : cmd_decode_pkg

// [testbench/ctrl_model.sv]
// Behavioural memory controller that drives the command pins
module ctrl_model (
    input wire logic clk,
    output cmd_decode_pkg::pins_s pins
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        pins = '{cke: 1'b1, cs_n: 1'b1, default: '0};
    end

    // ==========================================================
    // One command for one edge, then a no-operation at the same clock enable
    task automatic issue(input cmd_decode_pkg::pins_s p);
        cmd_decode_pkg::pins_s idle;
        idle = '{cke: p.cke, cs_n: 1'b0, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, default: '0};
        @(posedge clk);
        pins <= p;
        @(posedge clk);
        pins <= idle;
    endtask : issue
endmodule : ctrl_model

// [testbench/sdram_command_decoder_tb_top.sv]
// Self-checking bench for the command decoder
module sdram_command_decoder_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Signals
    logic clk, reset, clk_en, reset_n_pin, termination_control, burst_on_fly_mode, fixed_chop_mode;
    logic cmd_valid, burst_active, auto_precharge_done, refresh_start, termination_enable;
    logic [1:0] mode_register_select;
    logic [2:0] auto_precharge_bank;
    cmd_decode_pkg::pins_s pins;
    cmd_decode_pkg::dec_s cmd_out;
    cmd_decode_pkg::pwr_e power_state;
    int errors, checks;
    logic [31:0] seed = 32'h4501;

    ctrl_model u_ctrl (.clk(clk), .pins(pins));
    sdram_command_decoder u_dut (.clk(clk), .reset(reset), .clk_en(clk_en), .reset_n_pin(reset_n_pin),
        .pins(pins), .termination_control(termination_control), .burst_on_fly_mode(burst_on_fly_mode),
        .fixed_chop_mode(fixed_chop_mode), .cmd_out(cmd_out), .cmd_valid(cmd_valid),
        .mode_register_select(mode_register_select), .burst_active(burst_active),
        .auto_precharge_done(auto_precharge_done), .auto_precharge_bank(auto_precharge_bank),
        .refresh_start(refresh_start), .termination_enable(termination_enable), .power_state(power_state));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ==========================================================
    // Helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // Truth table for both clock enables high
    function automatic cmd_decode_pkg::cmd_e model(input cmd_decode_pkg::pins_s p);
        case ({p.cs_n, p.ras_n, p.cas_n, p.we_n})
            4'h0: return cmd_decode_pkg::CMD_MODE_REGISTER_SET;
            4'h1: return cmd_decode_pkg::CMD_REFRESH;
            4'h2: return p.auto_precharge_bit ? cmd_decode_pkg::CMD_PRECHARGE_ALL : cmd_decode_pkg::CMD_PRECHARGE;
            4'h3: return cmd_decode_pkg::CMD_ACTIVATE;
            4'h4: return cmd_decode_pkg::CMD_WRITE;
            4'h5: return cmd_decode_pkg::CMD_READ;
            4'h6: return p.auto_precharge_bit ? cmd_decode_pkg::CMD_CALIBRATION_LONG
                : cmd_decode_pkg::CMD_CALIBRATION_SHORT;
            4'h7: return cmd_decode_pkg::CMD_NOP;
            default: return cmd_decode_pkg::CMD_DESELECT;
        endcase
    endfunction : model

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic results();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results

    // The model's second edge is the first synchroniser edge; two more reach cmd_out
    task automatic step(input cmd_decode_pkg::pins_s p);
        u_ctrl.issue(p);
        repeat (2) @(posedge clk);
        #1;
    endtask : step

    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        results();
    end

    // ==========================================================
    // Main sequence
    initial begin
        cmd_decode_pkg::pins_s p;
        cmd_decode_pkg::cmd_e exp;
        int n, apn;
        logic chop;
        errors = 0;
        checks = 0;
        reset = 1'b1;
        clk_en = 1'b1;
        reset_n_pin = 1'b1;
        termination_control = 1'b1;
        burst_on_fly_mode = 1'b1;
        fixed_chop_mode = 1'b0;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        for (int r = 0; r < 4; r++) begin
            @(posedge clk);
            burst_on_fly_mode <= r[0];
            fixed_chop_mode <= r[1];
            repeat (3) @(posedge clk);
            for (int i = 0; i < 9; i++) begin
                seed = lfsr(seed);
                p = cmd_decode_pkg::pins_s'(seed[9:0]);
                p.cke = 1'b1;
                p.cs_n = (i == 8);
                if (i < 8) {p.ras_n, p.cas_n, p.we_n} = i[2:0];
                exp = model(p);
                chop = burst_on_fly_mode ? !p.burst_chop_bit : fixed_chop_mode;
                step(p);
                check(cmd_valid, exp != cmd_decode_pkg::CMD_NOP && exp != cmd_decode_pkg::CMD_DESELECT);
                if (i < 7) check(cmd_out.cmd, exp);
                if (i < 7) check(cmd_out.bank, p.bank);
                if (i == 0) check(mode_register_select, p.bank[1:0]);
                if (i == 1) check(refresh_start, 1'b1);
                if (i == 4 || i == 5) check(cmd_out.auto_precharge, p.auto_precharge_bit);
                if (i == 4 || i == 5) check(cmd_out.chopped_burst_four, chop);
                n = 0;
                apn = 0;
                for (int j = 0; j < 14; j++) begin
                    n += burst_active;
                    apn += auto_precharge_done;
                    if (auto_precharge_done) check(auto_precharge_bank, p.bank);
                    @(posedge clk);
                    #1;
                end
                check(n, (i == 4 || i == 5) ? (chop ? 4 : 8) : 0);
                check(apn, (i == 4 || i == 5) ? p.auto_precharge_bit : 1'b0);
            end
            $display("test decode round %0d done", r);
        end
        // Power states: all banks idle here, and no write follows the exit
        check(termination_enable, 1'b1);
        step('{cke: 1'b0, cs_n: 1'b0, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, default: '0});
        check(power_state, cmd_decode_pkg::ST_POWER_DOWN);
        step('{cke: 1'b0, cs_n: 1'b0, ras_n: 1'b0, cas_n: 1'b0, we_n: 1'b1, default: '0});
        check(refresh_start, 1'b0);
        check(power_state, cmd_decode_pkg::ST_POWER_DOWN);
        step('{cke: 1'b1, cs_n: 1'b1, default: '0});
        check(power_state, cmd_decode_pkg::ST_ACTIVE);
        step('{cke: 1'b0, cs_n: 1'b0, ras_n: 1'b0, cas_n: 1'b0, we_n: 1'b1, default: '0});
        check(power_state, cmd_decode_pkg::ST_SELF_REFRESH);
        repeat (3) @(posedge clk);
        check(termination_enable, 1'b0);
        step('{cke: 1'b1, cs_n: 1'b0, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, default: '0});
        check(power_state, cmd_decode_pkg::ST_ACTIVE);
        repeat (3) @(posedge clk);
        check(termination_enable, 1'b1);
        $display("test power states done");
        // Reads only from here on: no write may follow the self-refresh exit this soon
        p = '{cke: 1'b1, cs_n: 1'b0, ras_n: 1'b1, cas_n: 1'b0, we_n: 1'b1, burst_chop_bit: 1'b1, default: '0};
        step(p);
        p.bank = 3'h5;
        step(p);
        check(cmd_out.bank, 3'h5);
        check(cmd_out.cmd, cmd_decode_pkg::CMD_READ);
        n = 0;
        for (int j = 0; j < 16; j++) begin
            n += burst_active;
            @(posedge clk);
            if (j == 0) clk_en <= 1'b0;
            if (j == 6) clk_en <= 1'b1;
            #1;
        end
        check(n, 10);
        step('{cke: 1'b0, cs_n: 1'b1, default: '0});
        check(power_state, cmd_decode_pkg::ST_POWER_DOWN);
        @(posedge clk);
        reset_n_pin <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        check(power_state, cmd_decode_pkg::ST_ACTIVE);
        @(posedge clk);
        reset_n_pin <= 1'b1;
        step('{cke: 1'b1, cs_n: 1'b1, default: '0});
        @(posedge clk);
        termination_control <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        check(termination_enable, 1'b0);
        p = '{cke: 1'b1, cs_n: 1'b0, ras_n: 1'b1, cas_n: 1'b0, we_n: 1'b1, auto_precharge_bit: 1'b1, default: '0};
        step(p);
        check(burst_active, 1'b1);
        @(posedge clk);
        reset <= 1'b1;
        @(posedge clk);
        reset <= 1'b0;
        #1;
        check(burst_active, 1'b0);
        step('{cke: 1'b1, cs_n: 1'b0, ras_n: 1'b0, cas_n: 1'b0, we_n: 1'b0, bank: 3'h6, default: '0});
        check(cmd_out.cmd, cmd_decode_pkg::CMD_MODE_REGISTER_SET);
        check(mode_register_select, 2'h2);
        $display("test refusal, freeze and resets done");
        results();
    end
endmodule : sdram_command_decoder_tb_top
